/* File: logic/emad_pkg.sv */
// emad_pkg: constants and types for the external memory address decoder
// assumes a 20-bit cpu address space and an 8-bit mode control register
package emad_pkg;
  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  localparam int EMAD_AW = 20;
  localparam int EMAD_DW = 8;
  localparam logic [19:0] EMAD_PERI_LO_OFS = 20'h0_FFC0;
  localparam logic [19:0] EMAD_XPERI_LO = 20'h0_FFD0;
  localparam logic [19:0] EMAD_XPERI_HI = 20'h0_FFDF;
  localparam logic [19:0] EMAD_PERI_HI_OFS = 20'h0_FFFF;
  localparam logic [19:0] EMAD_ROM_BASE = 20'h0_0000;
  localparam logic [19:0] EMAD_ROM2_BASE = 20'h1_0000;
  localparam logic [19:0] EMAD_ROM_END_DEF = 20'h1_7FFF;
  localparam logic [15:0] EMAD_RAM_START_DEF = 16'hF100;
  localparam logic [3:0] EMAD_TOP_BANK = 4'hF;
  localparam logic [19:0] EMAD_MASK_256K = 20'h3_FFFF;
  localparam logic [19:0] EMAD_MASK_1M = 20'hF_FFFF;
  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  localparam logic [7:0] EMAD_MODE_RST = 8'h20;
  localparam int EMAD_MODE_LSB = 0;
  localparam logic [3:0] EMAD_MODE_SINGLE = 4'h0;
  localparam logic [3:0] EMAD_MODE_256K = 4'h8;
  localparam logic [3:0] EMAD_MODE_1M = 4'h9;
  typedef enum logic [1:0] {
    EMAD_TGT_ROM,
    EMAD_TGT_RAM,
    EMAD_TGT_PERI,
    EMAD_TGT_EXT
  } emad_target_t;
endpackage : emad_pkg

/* File: logic/emad_range.sv */
// emad_range: inclusive address window compare
// assumes bounds come from parameters or decoder logic on the same clock
`timescale 1ns/1ps
module emad_range (
  input wire logic [19:0] addr_i,
  input wire logic [19:0] lo_i,
  input wire logic [19:0] hi_i,
  output logic hit_o
);
  // combinational window test
  assign hit_o = (addr_i >= lo_i) && (addr_i <= hi_i);
endmodule : emad_range

/* File: logic/emad_decoder.sv */
// emad_decoder: decodes each cpu access into internal or external target
// assumes one access request pulse per access on the system clock
`timescale 1ns/1ps
// Contract
// - internal areas never reach external pins
// - internal hit: strobes stay inactive
// - address pins hold previous external level
// - address/data pins float on internal access
// - mask upper address bits outside 1 MB
// - default map: rom, ram, registers, rom2
// - relocated map: ram, registers in top bank
// - ram start per variant, moved when relocated
// - four-bit mode field, resets single-chip
// - address latch strobe only for external
module emad_decoder
  import emad_pkg::*;
#(
  parameter logic [19:0] ROM_END = emad_pkg::EMAD_ROM_END_DEF,
  parameter logic [15:0] RAM_START = emad_pkg::EMAD_RAM_START_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic access_i,
  input wire logic write_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic mode_we_i,
  input wire logic [7:0] mode_wdata_i,
  input wire logic relocate_i,
  input wire logic relocate_we_i,
  output logic [7:0] mode_o,
  output logic relocated_o,
  output emad_pkg::emad_target_t target_o,
  output logic internal_o,
  output logic address_latch_strobe_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic [19:8] addr_pin_o,
  output logic [7:0] ad_pin_o,
  output logic ad_pin_oe_o
);
  import emad_pkg::*;
  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  logic [7:0] memory_expansion_mode_reg;
  logic reloc_reg;
  emad_target_t target_reg;
  logic int_reg;
  logic latch_stb_reg;
  logic rd_n_reg;
  logic wr_n_reg;
  logic [19:8] addr_reg;
  logic [7:0] ad_reg;
  logic ad_oe_reg;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [3:0] mode_field;
  logic [3:0] bank;
  logic [19:0] ram_lo;
  logic [19:0] peri_lo;
  logic [19:0] peri_hi;
  logic [19:0] xperi_lo;
  logic [19:0] xperi_hi;
  logic [19:0] rom1_hi;
  logic [19:0] rom2_hi;
  logic hit_rom1;
  logic hit_rom2;
  logic hit_ram;
  logic hit_peri;
  logic hit_xperi;
  logic mode_legal;
  logic is_ext_mode;
  logic hit_int;
  logic [19:0] out_mask;
  logic [19:0] ext_addr;
  emad_target_t target_next;
  assign mode_field = memory_expansion_mode_reg[EMAD_MODE_LSB +: 4];
  assign is_ext_mode = (mode_field == EMAD_MODE_256K) ||
                       (mode_field == EMAD_MODE_1M);
  assign mode_legal = is_ext_mode || (mode_field == EMAD_MODE_SINGLE);
  // relocate moves ram and registers into the top bank
  assign bank = reloc_reg ? EMAD_TOP_BANK : 4'h0;
  // ram start keeps its low 16 bits in either map
  assign ram_lo = {bank, RAM_START};
  assign peri_lo = {bank, EMAD_PERI_LO_OFS[15:0]};
  assign peri_hi = {bank, EMAD_PERI_HI_OFS[15:0]};
  assign xperi_lo = {bank, EMAD_XPERI_LO[15:0]};
  assign xperi_hi = {bank, EMAD_XPERI_HI[15:0]};
  // default map splits rom around ram and registers
  assign rom1_hi = reloc_reg ? ROM_END : ram_lo - 20'h0_0001;
  assign rom2_hi = reloc_reg ? EMAD_ROM_BASE : ROM_END;
  emad_range u_rom1 (.addr_i(addr_i), .lo_i(EMAD_ROM_BASE),
    .hi_i(rom1_hi), .hit_o(hit_rom1));
  emad_range u_rom2 (.addr_i(addr_i), .lo_i(EMAD_ROM2_BASE),
    .hi_i(rom2_hi), .hit_o(hit_rom2));
  emad_range u_ram (.addr_i(addr_i), .lo_i(ram_lo),
    .hi_i(peri_lo - 20'h0_0001), .hit_o(hit_ram));
  emad_range u_peri (.addr_i(addr_i), .lo_i(peri_lo),
    .hi_i(peri_hi), .hit_o(hit_peri));
  emad_range u_xperi (.addr_i(addr_i), .lo_i(xperi_lo),
    .hi_i(xperi_hi), .hit_o(hit_xperi));
  // internal wins; external register window only in expansion
  assign hit_int = hit_rom1 || hit_rom2 || hit_ram ||
                   (hit_peri && !(hit_xperi && is_ext_mode)) ||
                   !is_ext_mode;
  assign target_next = (hit_rom1 || hit_rom2) ? EMAD_TGT_ROM :
                       hit_ram ? EMAD_TGT_RAM :
                       (hit_int && hit_peri) ? EMAD_TGT_PERI :
                       hit_int ? EMAD_TGT_ROM : EMAD_TGT_EXT;
  // drop upper bits unless 1 MB mode
  assign out_mask = (mode_field == EMAD_MODE_1M) ? EMAD_MASK_1M
                                                  : EMAD_MASK_256K;
  assign ext_addr = addr_i & out_mask;
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // mode and map control; illegal mode codes are stored but decode as single-chip
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      memory_expansion_mode_reg <= EMAD_MODE_RST;
      reloc_reg <= 1'b0;
    end else begin
      if (mode_we_i) begin
        memory_expansion_mode_reg <= mode_wdata_i;
      end
      if (relocate_we_i) begin
        reloc_reg <= relocate_i;
      end
    end
  end
  // strobes only on an external access
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      target_reg <= EMAD_TGT_ROM;
      int_reg <= 1'b1;
      latch_stb_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
    end else begin
      target_reg <= access_i ? target_next : target_reg;
      int_reg <= access_i ? hit_int : int_reg;
      // latch strobe high only for external
      latch_stb_reg <= access_i && !hit_int && mode_legal;
      rd_n_reg <= !(access_i && !hit_int && mode_legal && !write_i);
      wr_n_reg <= !(access_i && !hit_int && mode_legal && write_i);
    end
  end
  // address pins change only on external access
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_reg <= '0;
      ad_reg <= '0;
      ad_oe_reg <= 1'b0;
    end else begin
      if (access_i && !hit_int && mode_legal) begin
        addr_reg <= ext_addr[19:8];
        ad_reg <= write_i ? wdata_i : ext_addr[7:0];
      end
      ad_oe_reg <= access_i && !hit_int && mode_legal;
    end
  end
  assign mode_o = memory_expansion_mode_reg;
  assign relocated_o = reloc_reg;
  assign target_o = target_reg;
  assign internal_o = int_reg;
  assign address_latch_strobe_o = latch_stb_reg;
  assign read_strobe_n_o = rd_n_reg;
  assign write_strobe_n_o = wr_n_reg;
  assign addr_pin_o = addr_reg;
  assign ad_pin_o = ad_reg;
  assign ad_pin_oe_o = ad_oe_reg;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_int_access;
    access_i && hit_int;
  endsequence
  sequence s_ext_access;
    access_i && !hit_int && mode_legal;
  endsequence
  a_int_no_strobe: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_int_access |=> rd_n_reg && wr_n_reg)
    else $error("strobe active on internal access");
  a_int_no_latch: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_int_access |=> !latch_stb_reg)
    else $error("latch strobe on internal access");
  a_addr_holds: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_int_access |=> $stable(addr_reg))
    else $error("address pins moved on internal access");
  a_ad_floats: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_int_access |=> !ad_oe_reg)
    else $error("shared pins driven on internal access");
  a_mask_256k: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_ext_access and (mode_field == EMAD_MODE_256K))
      |=> addr_reg[19:18] == 2'h0)
    else $error("upper bits not masked in 256 KB mode");
  a_ram_internal: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    access_i && hit_ram |=> int_reg ##0 target_reg == EMAD_TGT_RAM)
    else $error("ram access went external");
  a_xperi_external: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    access_i && hit_xperi && is_ext_mode |=> !int_reg ##0 latch_stb_reg)
    else $error("external register window not external");
  a_ext_drive: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_ext_access ##1 !access_i |->
      latch_stb_reg ##0 ad_oe_reg ##1 !latch_stb_reg)
    else $error("external access strobe shape wrong");
  a_reset_mode: assert property (
    @(posedge clk_i) !rst_n_i |=> memory_expansion_mode_reg == EMAD_MODE_RST)
    else $error("mode register not reset");
  a_reloc_ram: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    access_i && reloc_reg && addr_i == {EMAD_TOP_BANK, RAM_START}
      |=> target_reg == EMAD_TGT_RAM)
    else $error("relocated ram start not internal");
endmodule : emad_decoder

/* File: dv/emad_ext_mem.sv */
// emad_ext_mem: external memory seen on the expansion bus
// assumes one-cycle registered strobes from the decoder
`timescale 1ns/1ps
module emad_ext_mem (
  input wire logic clk_i,
  input wire logic latch_stb_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [19:8] addr_hi_i,
  input wire logic [7:0] ad_i,
  input wire logic ad_oe_i,
  output logic [19:0] last_addr_o,
  output logic [7:0] last_wdata_o,
  output int n_cyc_o
);
  // --------------------------------------------------------------
  // capture address or data on each strobed cycle
  // --------------------------------------------------------------
  int cyc_cnt = 0;
  assign n_cyc_o = cyc_cnt;
  always @(posedge clk_i) begin
    if (latch_stb_i && ad_oe_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (!rd_n_i) last_addr_o <= {addr_hi_i, ad_i};
      if (!wr_n_i) last_wdata_o <= ad_i;
    end
  end
endmodule : emad_ext_mem

/* File: dv/emad_decoder_test.sv */
// emad_decoder_test: self-checking bench for the address decoder
// assumes emad_pkg and the ext memory model are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module emad_decoder_test;
  import emad_pkg::*;
  logic clk_i = 0, rst_n_i = 0, access_i = 0, write_i = 0;
  logic mode_we_i = 0, relocate_i = 0, relocate_we_i = 0;
  logic [19:0] addr_i = '0;
  logic [7:0] wdata_i = '0, mode_wdata_i = '0;
  logic [7:0] mode_o, ad_pin, m_wdata;
  logic relocated_o, internal_o, latch_stb, rd_n, wr_n, oe;
  emad_target_t target_o;
  logic [19:8] addr_pin;
  logic [19:0] m_addr;
  int m_cnt, exp_cnt = 0, err_count = 0, n_checks = 0;
  // --------------------------------------------------------------
  // clock, design and external memory
  // --------------------------------------------------------------
  initial forever #50 clk_i = ~clk_i;
  emad_decoder #(.ROM_END(20'h1_7FFF), .RAM_START(16'hF100)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .access_i(access_i),
    .write_i(write_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .mode_we_i(mode_we_i), .mode_wdata_i(mode_wdata_i),
    .relocate_i(relocate_i), .relocate_we_i(relocate_we_i),
    .mode_o(mode_o), .relocated_o(relocated_o), .target_o(target_o),
    .internal_o(internal_o), .address_latch_strobe_o(latch_stb),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .addr_pin_o(addr_pin), .ad_pin_o(ad_pin), .ad_pin_oe_o(oe));
  emad_ext_mem ext (.clk_i(clk_i), .latch_stb_i(latch_stb), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_hi_i(addr_pin), .ad_i(ad_pin), .ad_oe_i(oe),
    .last_addr_o(m_addr), .last_wdata_o(m_wdata), .n_cyc_o(m_cnt));
  // one access, then the cycle after it
  task automatic do_acc(input logic [19:0] a, input logic w,
    input logic [7:0] d, input emad_target_t t, input logic x,
    input logic [19:8] hi);
    @(negedge clk_i);
    access_i = 1;
    write_i = w;
    addr_i = a;
    wdata_i = d;
    @(negedge clk_i);
    access_i = 0;
    `CHK("target", t, target_o)
    `CHK("internal", !x, internal_o)
    `CHK("latch_stb", x, latch_stb)
    `CHK("rd_n", !(x && !w), rd_n)
    `CHK("wr_n", !(x && w), wr_n)
    `CHK("oe", x, oe)
    `CHK("addr_pin", hi, addr_pin)
    if (x) `CHK("ad_pin", w ? d : a[7:0], ad_pin)
    @(negedge clk_i);
    exp_cnt += x;
    `CHK("latch_stb_end", 1'b0, latch_stb)
    `CHK("strobe_end", 3'h6, {rd_n, wr_n, oe})
    `CHK("ext_count", exp_cnt, m_cnt)
    if (x && !w) `CHK("ext_addr", {hi, a[7:0]}, m_addr)
    if (x && w) `CHK("ext_wdata", d, m_wdata)
  endtask : do_acc
  task automatic set_cfg(input logic [7:0] m, input logic r);
    @(negedge clk_i);
    mode_we_i = 1;
    mode_wdata_i = m;
    relocate_we_i = 1;
    relocate_i = r;
    @(negedge clk_i);
    mode_we_i = 0;
    relocate_we_i = 0;
    `CHK("mode", m, mode_o)
    `CHK("relocated", r, relocated_o)
  endtask : set_cfg
  task automatic t_reset();
    `CHK("mode_rst", 8'h20, mode_o)
    `CHK("reloc_rst", 1'b0, relocated_o)
    `CHK("idle", 4'h6, {latch_stb, rd_n, wr_n, oe})
  endtask : t_reset
  task automatic t_single();
    do_acc(20'h2_0000, 0, 8'h00, EMAD_TGT_ROM, 0, 12'h000);
    set_cfg(8'h03, 0);
    do_acc(20'h2_0000, 1, 8'h5A, EMAD_TGT_ROM, 0, 12'h000);
  endtask : t_single
  task automatic t_256k();
    set_cfg(8'h08, 0);
    do_acc(20'h5_4321, 0, 8'h00, EMAD_TGT_EXT, 1, 12'h143);
    do_acc(20'h6_7821, 1, 8'hA5, EMAD_TGT_EXT, 1, 12'h278);
    do_acc(20'h0_F100, 1, 8'h3C, EMAD_TGT_RAM, 0, 12'h278);
    do_acc(20'h0_FFC0, 0, 8'h00, EMAD_TGT_PERI, 0, 12'h278);
    do_acc(20'h0_FFD0, 0, 8'h00, EMAD_TGT_EXT, 1, 12'h0FF);
    do_acc(20'h1_0000, 0, 8'h00, EMAD_TGT_ROM, 0, 12'h0FF);
    do_acc(20'h1_8000, 0, 8'h00, EMAD_TGT_EXT, 1, 12'h180);
  endtask : t_256k
  task automatic t_reloc();
    set_cfg(8'h09, 0);
    do_acc(20'h5_4321, 0, 8'h00, EMAD_TGT_EXT, 1, 12'h543);
    set_cfg(8'h09, 1);
    do_acc(20'hF_F100, 0, 8'h00, EMAD_TGT_RAM, 0, 12'h543);
    do_acc(20'hF_FFE0, 0, 8'h00, EMAD_TGT_PERI, 0, 12'h543);
    do_acc(20'hF_FFD0, 0, 8'h00, EMAD_TGT_EXT, 1, 12'hFFF);
    do_acc(20'h0_F100, 0, 8'h00, EMAD_TGT_ROM, 0, 12'hFFF);
    do_acc(20'h2_0000, 1, 8'hC3, EMAD_TGT_EXT, 1, 12'h200);
  endtask : t_reloc
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1;
    t_reset();
    t_single();
    t_256k();
    t_reloc();
    end_sim();
  end
  initial begin
    #100us;
    err_count++;
    end_sim();
  end
endmodule : emad_decoder_test
